/* common/lead_off_pkg.sv */
package lead_off_pkg;

	// Bus geometry and the word size that the slave accepts.
	localparam int unsigned DATA_W = 32;
	localparam int unsigned CTRL_W = 24;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	// Byte addresses of the registers, each one aligned word.
	localparam logic [7:0] ADDR_LEAD_OFF_CONTROL = 8'h08;
	localparam logic [7:0] ADDR_CAL_CONTROL = 8'h0C;
	localparam logic [7:0] ADDR_DETECT_STATUS = 8'h10;

	// Reset values.
	localparam logic [23:0] LEAD_OFF_CONTROL_RESET = 24'h000000;
	localparam logic CAL_CONTROL_RESET = 1'h0;

	// Writable bits of the lead-off control word; reserved bits stay zero.
	localparam logic [23:0] LEAD_OFF_CONTROL_MASK = 24'hE7919F;

	// Field positions of the lead-off control word.
	localparam int unsigned LEFT_ARM_PHASE_BIT = 23;
	localparam int unsigned LEFT_LEG_PHASE_BIT = 22;
	localparam int unsigned RIGHT_ARM_PHASE_BIT = 21;
	localparam int unsigned COMMON_PHASE_BIT = 18;
	localparam int unsigned LEFT_ARM_AC_EN_BIT = 17;
	localparam int unsigned LEFT_LEG_AC_EN_BIT = 16;
	localparam int unsigned RIGHT_ARM_AC_EN_BIT = 15;
	localparam int unsigned COMMON_AC_EN_BIT = 12;
	localparam int unsigned AC_LEVEL_HI = 8;
	localparam int unsigned AC_LEVEL_LO = 7;
	localparam int unsigned DC_LEVEL_HI = 4;
	localparam int unsigned DC_LEVEL_LO = 2;
	localparam int unsigned AC_METHOD_BIT = 1;
	localparam int unsigned MASTER_EN_BIT = 0;

	// Calibration control word and detect status word layouts.
	localparam int unsigned CAL_DAC_EN_BIT = 0;
	localparam int unsigned STATUS_DC_DETECT_BIT = 4;

	// Excitation current scales: dc in nA, ac in tenths of nA rms.
	localparam logic [6:0] DC_STEP_NA = 7'h0A;
	localparam logic [9:0] AC_BASE_TENTH_NA = 10'h07D;

	// AHB transfer phase tracking.
	typedef enum logic [1:0] {
		PHASE_IDLE,
		PHASE_WRITE,
		PHASE_READ
	} bus_phase_t;

endpackage : lead_off_pkg

/* hdl/lead_off_detect_control.sv */
`timescale 1ns/1ps
// How it works
// - Bits 23, 22 and 21 set the ac excitation phase of LA, LL and RA, one meaning inverted.
// - Bit 18 sets the ac excitation phase of CE, one meaning inverted by 180 degrees.
// - The ac enable of LA, LL and RA is its own bit (17, 16, 15) ORed with the ac select bit.
// - CE ac detection is enabled by bit 12 alone and the ac select bit never reaches it.
// - Field [8:7] picks the ac current: 12.5, 25, 50 or 100 nA rms.
// - Field [4:2] picks the dc current in 10 nA steps and acts only while ac select is zero.
// - With detection on, bit 1 clear means dc detection, bit 1 set means ac on all but CE.
// - The ac select bit counts for nothing while the master enable is zero.
// - While the calibration DAC is on, every ac enable is forced off.
// - Bit 0 is the master detection enable, zero after reset.
module lead_off_detect_control
	import lead_off_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [31:0] hrdata,
	output logic leftArmAcEn,
	output logic leftLegAcEn,
	output logic rightArmAcEn,
	output logic commonAcEn,
	output logic leftArmPhaseInvert,
	output logic leftLegPhaseInvert,
	output logic rightArmPhaseInvert,
	output logic commonPhaseInvert,
	output logic dcDetectEn,
	output logic [2:0] dcExciteLevel,
	output logic [6:0] dcExciteNa,
	output logic [1:0] acExciteLevel,
	output logic [9:0] acExciteTenthNa,
	output logic calDacEn
);

	// Dc current in nA grows linearly with the code.
	function automatic logic [6:0] dc_current_na(input logic [2:0] code);
		logic [9:0] prod;
		prod = {7'h00, code} * {3'h0, DC_STEP_NA};
		return prod[6:0];
	endfunction : dc_current_na

	// Ac current doubles with each code step from 12.5 nA rms.
	function automatic logic [9:0] ac_current_tenth_na(input logic [1:0] code);
		return AC_BASE_TENTH_NA << code;
	endfunction : ac_current_tenth_na

	logic [23:0] leadOffControl_q;
	logic [23:0] leadOffControl_d;
	logic calControl_q;
	logic calControl_d;
	bus_phase_t phase_q;
	logic [7:0] addr_q;
	logic accessStart;
	logic wordAccess;
	logic writeCtrl;
	logic writeCal;

	logic masterEn;
	logic acMethod;
	logic acPath;
	logic laAcNext;
	logic llAcNext;
	logic raAcNext;
	logic ceAcNext;
	logic dcNext;
	logic anyAcNext;

	// An address phase is taken only when the previous transfer has finished.
	assign accessStart = hsel && htrans[1] && hready;
	assign wordAccess = (hsize == HSIZE_WORD);

	// Address phase capture; non-word sizes fall through as idle and are answered OKAY.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= PHASE_IDLE;
			addr_q <= 8'h00;
		end else if (hready) begin
			if (accessStart && wordAccess) begin
				phase_q <= hwrite ? PHASE_WRITE : PHASE_READ;
				addr_q <= haddr;
			end else begin
				phase_q <= PHASE_IDLE;
			end
		end
	end

	// Write data arrives in the data phase; unmapped addresses are simply dropped.
	assign writeCtrl = (phase_q == PHASE_WRITE) && (addr_q == ADDR_LEAD_OFF_CONTROL);
	assign writeCal = (phase_q == PHASE_WRITE) && (addr_q == ADDR_CAL_CONTROL);

	// Reserved bits are masked so they can never hold a one.
	always_comb begin
		leadOffControl_d = leadOffControl_q;
		if (writeCtrl) begin
			leadOffControl_d = hwdata[23:0] & LEAD_OFF_CONTROL_MASK;
		end
	end

	always_comb begin
		calControl_d = calControl_q;
		if (writeCal) begin
			calControl_d = hwdata[CAL_DAC_EN_BIT];
		end
	end

	// Control word storage; master enable clears with the rest at reset.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			leadOffControl_q <= LEAD_OFF_CONTROL_RESET;
		end else begin
			leadOffControl_q <= leadOffControl_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			calControl_q <= CAL_CONTROL_RESET;
		end else begin
			calControl_q <= calControl_d;
		end
	end

	// Read data of both control words is sampled from the next-state values so a read right after a
	// write already sees the new word, without adding a wait state.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h00000000;
		end else if (hready && accessStart && wordAccess && !hwrite) begin
			case (haddr)
				ADDR_LEAD_OFF_CONTROL: hrdata <= {8'h00, leadOffControl_d};
				ADDR_CAL_CONTROL: hrdata <= {31'h00000000, calControl_d};
				ADDR_DETECT_STATUS: hrdata <= {27'h0000000, dcDetectEn, commonAcEn,
					rightArmAcEn, leftLegAcEn, leftArmAcEn};
				default: hrdata <= 32'h00000000;
			endcase
		end else begin
			hrdata <= 32'h00000000;
		end
	end

	// The slave never stalls and always answers OKAY.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
		end
	end

	// Effective detection state. The ac select only counts with the master on.
	assign masterEn = leadOffControl_q[MASTER_EN_BIT];
	assign acMethod = masterEn && leadOffControl_q[AC_METHOD_BIT];
	// Calibration DAC and master enable gate the whole ac path.
	assign acPath = masterEn && !calControl_q;
	assign laAcNext = acPath && (leadOffControl_q[LEFT_ARM_AC_EN_BIT] || acMethod);
	assign llAcNext = acPath && (leadOffControl_q[LEFT_LEG_AC_EN_BIT] || acMethod);
	assign raAcNext = acPath && (leadOffControl_q[RIGHT_ARM_AC_EN_BIT] || acMethod);
	assign ceAcNext = acPath && leadOffControl_q[COMMON_AC_EN_BIT];
	// Dc detection runs while enabled and not switched over to ac.
	assign dcNext = masterEn && !leadOffControl_q[AC_METHOD_BIT];
	assign anyAcNext = laAcNext || llAcNext || raAcNext || ceAcNext;

	// Per-electrode ac enables to the analog front end.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			leftArmAcEn <= 1'b0;
			leftLegAcEn <= 1'b0;
			rightArmAcEn <= 1'b0;
			commonAcEn <= 1'b0;
		end else begin
			leftArmAcEn <= laAcNext;
			leftLegAcEn <= llAcNext;
			rightArmAcEn <= raAcNext;
			commonAcEn <= ceAcNext;
		end
	end

	// Phase bits pass straight through; they matter only while ac drive is on.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			leftArmPhaseInvert <= 1'b0;
			leftLegPhaseInvert <= 1'b0;
			rightArmPhaseInvert <= 1'b0;
			commonPhaseInvert <= 1'b0;
		end else begin
			leftArmPhaseInvert <= leadOffControl_q[LEFT_ARM_PHASE_BIT];
			leftLegPhaseInvert <= leadOffControl_q[LEFT_LEG_PHASE_BIT];
			rightArmPhaseInvert <= leadOffControl_q[RIGHT_ARM_PHASE_BIT];
			commonPhaseInvert <= leadOffControl_q[COMMON_PHASE_BIT];
		end
	end

	// Dc current reaches the pins only while dc detection is live; a zero level
	// keeps the excitation source quiet instead of relying on a separate gate.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dcDetectEn <= 1'b0;
			dcExciteLevel <= 3'h0;
			dcExciteNa <= 7'h00;
		end else begin
			dcDetectEn <= dcNext;
			if (dcNext) begin
				dcExciteLevel <= leadOffControl_q[DC_LEVEL_HI:DC_LEVEL_LO];
				dcExciteNa <= dc_current_na(leadOffControl_q[DC_LEVEL_HI:DC_LEVEL_LO]);
			end else begin
				dcExciteLevel <= 3'h0;
				dcExciteNa <= 7'h00;
			end
		end
	end

	// Ac current in tenths of nA is reported only while some electrode has ac drive; the level code always follows its field.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			acExciteLevel <= 2'h0;
			acExciteTenthNa <= 10'h000;
			calDacEn <= 1'b0;
		end else begin
			acExciteLevel <= leadOffControl_q[AC_LEVEL_HI:AC_LEVEL_LO];
			if (anyAcNext) begin
				acExciteTenthNa <= ac_current_tenth_na(leadOffControl_q[AC_LEVEL_HI:AC_LEVEL_LO]);
			end else begin
				acExciteTenthNa <= 10'h000;
			end
			calDacEn <= calControl_q;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_phase_follow;
		$past(leadOffControl_q[LEFT_ARM_PHASE_BIT]) == leftArmPhaseInvert
			&& $past(leadOffControl_q[LEFT_LEG_PHASE_BIT]) == leftLegPhaseInvert
			&& $past(leadOffControl_q[RIGHT_ARM_PHASE_BIT]) == rightArmPhaseInvert;
	endproperty
	a_phase_follow: assert property (p_phase_follow)
		else $error("Arm phase outputs do not follow the control word.");

	property p_common_phase;
		writeCal == 1'b0 && writeCtrl ##1 1'b1 |=> commonPhaseInvert == $past(leadOffControl_q[COMMON_PHASE_BIT]);
	endproperty
	a_common_phase: assert property (p_common_phase)
		else $error("Common phase output does not follow its bit.");

	property p_arm_or;
		acPath && leadOffControl_q[AC_METHOD_BIT] |=> leftArmAcEn && leftLegAcEn && rightArmAcEn;
	endproperty
	a_arm_or: assert property (p_arm_or)
		else $error("Ac select did not enable all three arm and leg electrodes.");

	property p_common_alone;
		acPath && !leadOffControl_q[COMMON_AC_EN_BIT] |=> !commonAcEn;
	endproperty
	a_common_alone: assert property (p_common_alone)
		else $error("Common electrode ac enabled without its own bit.");

	property p_ac_level;
		anyAcNext && leadOffControl_q[AC_LEVEL_HI:AC_LEVEL_LO] == 2'h3 |=> acExciteTenthNa == 10'h3E8;
	endproperty
	a_ac_level: assert property (p_ac_level)
		else $error("Ac current code three did not give 100 nA rms.");

	property p_dc_level;
		dcNext && leadOffControl_q[DC_LEVEL_HI:DC_LEVEL_LO] == 3'h7 |=> dcExciteNa == 7'h46;
	endproperty
	a_dc_level: assert property (p_dc_level)
		else $error("Dc current code seven did not give 70 nA.");

	property p_ac_method_dc_off;
		masterEn && leadOffControl_q[AC_METHOD_BIT] |=> !dcDetectEn && dcExciteNa == 7'h00;
	endproperty
	a_ac_method_dc_off: assert property (p_ac_method_dc_off)
		else $error("Dc detection stayed on with ac method selected.");

	property p_select_ignored;
		!masterEn |=> !leftArmAcEn && !dcDetectEn;
	endproperty
	a_select_ignored: assert property (p_select_ignored)
		else $error("Ac select acted while detection was disabled.");

	property p_cal_forces_off;
		calControl_q |=> !(leftArmAcEn || leftLegAcEn || rightArmAcEn || commonAcEn);
	endproperty
	a_cal_forces_off: assert property (p_cal_forces_off)
		else $error("Ac enable active while the calibration DAC is on.");

	property p_write_master;
		writeCtrl && hwdata[MASTER_EN_BIT] && !hwdata[AC_METHOD_BIT] ##1 !writeCtrl
			|=> dcDetectEn;
	endproperty
	a_write_master: assert property (p_write_master)
		else $error("Writing the master enable did not start dc detection two edges later.");

	property p_master_gate;
		!masterEn |=> acExciteTenthNa == 10'h000 && dcExciteLevel == 3'h0 && !commonAcEn;
	endproperty
	a_master_gate: assert property (p_master_gate)
		else $error("Excitation present with the master enable clear.");

	property p_reserved_zero;
		(leadOffControl_q & ~LEAD_OFF_CONTROL_MASK) == 24'h000000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("A reserved control bit holds a one.");

	property p_cal_copy;
		calDacEn == $past(calControl_q);
	endproperty
	a_cal_copy: assert property (p_cal_copy)
		else $error("Calibration DAC output does not follow its control bit.");

	property p_ac_quiet;
		!anyAcNext |=> acExciteTenthNa == 10'h000;
	endproperty
	a_ac_quiet: assert property (p_ac_quiet)
		else $error("Ac current reported with no electrode in ac drive.");

	property p_dc_field;
		dcNext |=> dcExciteLevel == $past(leadOffControl_q[DC_LEVEL_HI:DC_LEVEL_LO]);
	endproperty
	a_dc_field: assert property (p_dc_field)
		else $error("Dc level output does not follow its field during dc detection.");

	property p_dc_select_clear;
		masterEn && !leadOffControl_q[AC_METHOD_BIT] |=> dcDetectEn;
	endproperty
	a_dc_select_clear: assert property (p_dc_select_clear)
		else $error("Dc detection off although enabled with ac select clear.");

endmodule : lead_off_detect_control

/* sim/ahb_host_model.sv */
`timescale 1ns/1ps
// Host side of the register bus: single word transfers, one at a time.
module ahb_host_model
	import lead_off_pkg::*;
(
	input wire logic clk_sys,
	input wire logic hreadyIn,
	input wire logic [31:0] hrdataIn,
	output logic hsel,
	output logic [7:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	// Idle bus at time zero.
	initial begin
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h00000000;
	end

	// Address phase held until hready is seen high, then htrans goes idle and the address shows its inverse.
	task automatic addrPhase(input logic [7:0] addr, input logic wr);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= addr;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		@(posedge clk_sys);
		while (hreadyIn !== 1'b1) @(posedge clk_sys);
		htrans <= 2'h0;
		haddr <= ~addr;
	endtask : addrPhase

	// Reserved bits of the lead-off control word are never set, since the slave gives them no meaning.
	task automatic busWrite(input logic [7:0] addr, input logic [31:0] data);
		logic [31:0] d;
		d = data;
		if (addr == ADDR_LEAD_OFF_CONTROL) d = data & {8'h00, LEAD_OFF_CONTROL_MASK};
		addrPhase(addr, 1'b1);
		hwdata <= d;
		@(posedge clk_sys);
		while (hreadyIn !== 1'b1) @(posedge clk_sys);
		hwdata <= ~d;
	endtask : busWrite

	// Read data is taken at the edge that ends the data phase.
	task automatic busRead(input logic [7:0] addr, output logic [31:0] data);
		addrPhase(addr, 1'b0);
		@(posedge clk_sys);
		while (hreadyIn !== 1'b1) @(posedge clk_sys);
		data = hrdataIn;
	endtask : busRead

endmodule : ahb_host_model

/* sim/test_lead_off_detect_control.sv */
`timescale 1ns/1ps
module test_lead_off_detect_control
	import lead_off_pkg::*;
;
	logic clk_sys;
	logic rst_n;
	logic hsel, hwrite, hreadyout;
	logic [7:0] haddr;
	logic [1:0] htrans, hresp, acExciteLevel;
	logic [2:0] hsize, dcExciteLevel;
	logic [31:0] hwdata, hrdata, rd;
	logic laEn, llEn, raEn, ceEn, left_arm_phase_invert, left_leg_phase_invert, right_arm_phase_invert, common_electrode_phase_invert, dcDetectEn, calDacEn;
	logic [6:0] dcExciteNa;
	logic [9:0] acExciteTenthNa;
	int failures = 0;
	int num_checks = 0;
	wire [3:0] acEn = {laEn, llEn, raEn, ceEn};
	wire [3:0] phase = {left_arm_phase_invert, left_leg_phase_invert, right_arm_phase_invert, common_electrode_phase_invert};

	lead_off_detect_control DUT (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .leftArmAcEn(laEn),
		.leftLegAcEn(llEn), .rightArmAcEn(raEn), .commonAcEn(ceEn), .leftArmPhaseInvert(left_arm_phase_invert),
		.leftLegPhaseInvert(left_leg_phase_invert), .rightArmPhaseInvert(right_arm_phase_invert), .commonPhaseInvert(common_electrode_phase_invert),
		.dcDetectEn(dcDetectEn), .dcExciteLevel(dcExciteLevel), .dcExciteNa(dcExciteNa),
		.acExciteLevel(acExciteLevel), .acExciteTenthNa(acExciteTenthNa), .calDacEn(calDacEn));

	ahb_host_model host (.clk_sys(clk_sys), .hreadyIn(hreadyout), .hrdataIn(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// Clock at 100 ns period.
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// Outputs follow one edge after the register update, so settle two edges before looking.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.busWrite(a, d);
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : wr

	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude

	// A hang is cut short well beyond the about 150 cycles the tests need.
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		conclude();
	end

	int acBit[4] = '{LEFT_ARM_AC_EN_BIT, LEFT_LEG_AC_EN_BIT, RIGHT_ARM_AC_EN_BIT, COMMON_AC_EN_BIT};
	int phBit[4] = '{LEFT_ARM_PHASE_BIT, LEFT_LEG_PHASE_BIT, RIGHT_ARM_PHASE_BIT, COMMON_PHASE_BIT};

	initial begin
		rst_n = 1'b0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		host.busRead(ADDR_LEAD_OFF_CONTROL, rd);
		chk("reset value", {8'h00, LEAD_OFF_CONTROL_RESET}, rd);
		chk("reset enables", 32'h0, {acEn, phase, dcDetectEn});
		$display("reset test done");
		// All four ac enables, ac select and dc level 7 requested, but the master enable is off.
		wr(ADDR_LEAD_OFF_CONTROL, 32'h0003901E);
		chk("off enables", 32'h0, {acEn, dcDetectEn, dcExciteLevel});
		chk("off currents", 32'h0, {dcExciteNa, acExciteTenthNa});
		host.busRead(ADDR_LEAD_OFF_CONTROL, rd);
		chk("readback", 32'h0003901E, rd);
		$display("master off test done");
		for (int c = 0; c < 8; c++) begin
			wr(ADDR_LEAD_OFF_CONTROL, (c << 2) | 1);
			chk("dc enable", 32'h01, {acEn, dcDetectEn});
			chk("dc level", c, dcExciteLevel);
			chk("dc current", c * 10, dcExciteNa);
		end
		$display("dc test done");
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_LEAD_OFF_CONTROL, (c << 7) | 32'h1F);
			chk("ac select enables", 32'h1C, {acEn, dcDetectEn});
			chk("ac level", c, acExciteLevel);
			chk("ac current", 32'(AC_BASE_TENTH_NA) << c, acExciteTenthNa);
			chk("dc gated", 32'h0, {dcExciteLevel, dcExciteNa});
		end
		$display("ac test done");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_LEAD_OFF_CONTROL, (1 << acBit[i]) | 1);
			chk("own ac enable", {4'b1000 >> i, 1'b1}, {acEn, dcDetectEn});
			wr(ADDR_LEAD_OFF_CONTROL, 1 << phBit[i]);
			chk("phase", 4'b1000 >> i, phase);
		end
		$display("per electrode test done");
		wr(ADDR_LEAD_OFF_CONTROL, 32'h0003901F);
		wr(ADDR_CAL_CONTROL, 32'h1);
		chk("cal forces off", 32'h01, {acEn, calDacEn});
		wr(ADDR_CAL_CONTROL, 32'h0);
		chk("cal released", 32'h1E, {acEn, calDacEn});
		// Status shows the three arm and leg enables from their own bits and ac select, and CE from its own bit.
		host.busRead(ADDR_DETECT_STATUS, rd);
		chk("status", 32'h0F, rd);
		$display("calibration test done");
		// A reset in mid-run must bring the whole control word back to its default.
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		host.busRead(ADDR_LEAD_OFF_CONTROL, rd);
		chk("reset again value", {8'h00, LEAD_OFF_CONTROL_RESET}, rd);
		chk("reset again enables", 32'h0, {acEn, dcDetectEn, calDacEn});
		$display("mid-run reset test done");
		host.busWrite(8'h20, 32'hFFFFFFFF);
		host.busRead(8'h20, rd);
		chk("unmapped", 32'h0, rd);
		chk("response", HRESP_OKAY, hresp);
		$display("unmapped test done");
		conclude();
	end
endmodule : test_lead_off_detect_control
